// [hw/peripheral_irq_flag_bank.sv]
// Peripheral interrupt request flag bank with register port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Flags set on event, regardless of enables
// - Flag one means pending; flags read/write
// - Register two layout; bit 1 reads zero
// - Register three layout; bits 7,2,0 zero
// - All flags reset to zero
// - Pending needs peripheral enable bit set
module peripheral_irq_flag_bank (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Event sources, one-cycle pulses from same-clock peripherals
   input wire logic osc_fail_evt,
   input wire logic comparator_two_evt,
   input wire logic comparator_one_evt,
   input wire logic eeprom_write_done_evt,
   input wire logic serial_bus_collision_evt,
   input wire logic lcd_module_evt,
   input wire logic capcomp_two_evt,
   input wire logic capcomp_three_evt,
   input wire logic capcomp_four_evt,
   input wire logic capcomp_five_evt,
   input wire logic timer_six_match_evt,
   input wire logic timer_four_match_evt,
   // Toward the processor
   output logic peripheral_pending,
   output logic irq
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic wr_two, wr_three, wr_en2, wr_en3, wr_glb, wr_st, wr_mask;
   assign wr_two = reg_wr && reg_addr == irq_flag_pkg::OFF_FLAGS_TWO;
   assign wr_three = reg_wr && reg_addr == irq_flag_pkg::OFF_FLAGS_THREE;
   assign wr_en2 = reg_wr && reg_addr == irq_flag_pkg::OFF_ENABLE_TWO;
   assign wr_en3 = reg_wr && reg_addr == irq_flag_pkg::OFF_ENABLE_THREE;
   assign wr_glb = reg_wr && reg_addr == irq_flag_pkg::OFF_GLOBAL_CTRL;
   assign wr_st = reg_wr && reg_addr == irq_flag_pkg::OFF_IRQ_STATUS;
   assign wr_mask = reg_wr && reg_addr == irq_flag_pkg::OFF_IRQ_MASK;
   // ----------------------------------------
   // Flag registers
   // ----------------------------------------
   logic [7:0] set_two, set_three, flags_two, flags_three;
   logic evt_two, evt_three;
   // Bit order fixes the layout; unimplemented bits are tied low
   assign set_two = {osc_fail_evt, comparator_two_evt, comparator_one_evt, eeprom_write_done_evt,
                     serial_bus_collision_evt, lcd_module_evt, 1'b0, capcomp_two_evt};
   assign set_three = {1'b0, capcomp_five_evt, capcomp_four_evt, capcomp_three_evt,
                       timer_six_match_evt, 1'b0, timer_four_match_evt, 1'b0};
   // Sets ignore every enable bit
   flag_reg #(.IMPL(irq_flag_pkg::MASK_TWO)) u_flags_two (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(wr_two),
      .wr_data(reg_wdata),
      .set_in(set_two),
      .flags(flags_two),
      .new_event(evt_two)
   );
   flag_reg #(.IMPL(irq_flag_pkg::MASK_THREE)) u_flags_three (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(wr_three),
      .wr_data(reg_wdata),
      .set_in(set_three),
      .flags(flags_three),
      .new_event(evt_three)
   );
   // ----------------------------------------
   // Enable, control and interrupt registers
   // ----------------------------------------
   logic [7:0] enable_two_reg, enable_three_reg, global_reg, status_reg, mask_reg;
   logic [7:0] status_next, status_set;
   assign status_set = {6'h00, evt_three, evt_two};
   // Write-one-to-clear, a new event wins
   assign status_next = ((status_reg & ~(wr_st ? reg_wdata : 8'h00)) | status_set) & irq_flag_pkg::MASK_STATUS;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         enable_two_reg <= irq_flag_pkg::RESET_VALUE;
         enable_three_reg <= irq_flag_pkg::RESET_VALUE;
         global_reg <= irq_flag_pkg::RESET_VALUE;
         status_reg <= irq_flag_pkg::RESET_VALUE;
         mask_reg <= irq_flag_pkg::RESET_VALUE;
      end else begin
         if (wr_en2) enable_two_reg <= reg_wdata & irq_flag_pkg::MASK_TWO;
         if (wr_en3) enable_three_reg <= reg_wdata & irq_flag_pkg::MASK_THREE;
         if (wr_glb) global_reg <= reg_wdata & irq_flag_pkg::MASK_GLOBAL;
         if (wr_mask) mask_reg <= reg_wdata & irq_flag_pkg::MASK_STATUS;
         status_reg <= status_next;
      end
   end
   // ----------------------------------------
   // Pending outputs
   // ----------------------------------------
   logic any_enabled;
   // Stale flags fire at once when enabled; software clears first
   assign any_enabled = |((flags_two & enable_two_reg) | (flags_three & enable_three_reg));
   assign peripheral_pending = any_enabled && global_reg[irq_flag_pkg::PERIPH_EN_BIT];
   assign irq = |(status_reg & mask_reg);
   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   logic [7:0] rd_mux, rdata_reg;
   assign rd_mux = reg_addr == irq_flag_pkg::OFF_FLAGS_TWO ? flags_two :
                   reg_addr == irq_flag_pkg::OFF_FLAGS_THREE ? flags_three :
                   reg_addr == irq_flag_pkg::OFF_ENABLE_TWO ? enable_two_reg :
                   reg_addr == irq_flag_pkg::OFF_ENABLE_THREE ? enable_three_reg :
                   reg_addr == irq_flag_pkg::OFF_GLOBAL_CTRL ? global_reg :
                   reg_addr == irq_flag_pkg::OFF_IRQ_STATUS ? status_reg :
                   reg_addr == irq_flag_pkg::OFF_IRQ_MASK ? mask_reg : 8'h00;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_reg <= irq_flag_pkg::RESET_VALUE;
      end else begin
         rdata_reg <= reg_rd ? rd_mux : 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_flag_set_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      osc_fail_evt |=> flags_two[7]) else $error("event did not set flag");
   a_three_set_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      timer_four_match_evt |=> flags_three[1]) else $error("timer four flag not set");
   a_write_clears_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_two && !reg_wdata[0] && !capcomp_two_evt) |=> !flags_two[0]) else $error("flag not cleared");
   a_two_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      flags_two[1] == 1'b0) else $error("unused bit set in two");
   a_three_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (flags_three & ~irq_flag_pkg::MASK_THREE) == 8'h00) else $error("unused bit set in three");
   a_reset_clears_flags: assert property (@(posedge ref_clk)
      !rst_n |=> (flags_two == 8'h00 && flags_three == 8'h00)) else $error("flags not zero after reset");
   a_gate_periph_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !global_reg[irq_flag_pkg::PERIPH_EN_BIT] |-> !peripheral_pending) else $error("pending without enable");
   a_pending_from_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (capcomp_five_evt && enable_three_reg[6] && global_reg[6] && !wr_three && !wr_en3 && !wr_glb)
      |=> peripheral_pending) else $error("pending did not rise");
   a_read_data_timing: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == irq_flag_pkg::OFF_FLAGS_TWO) |=> reg_rdata == $past(flags_two))
      else $error("read data wrong");
   // Read data must not linger past its one cycle
   a_idle_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data left standing");
   a_unmapped_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr > irq_flag_pkg::OFF_IRQ_MASK) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_write_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_three && reg_wdata[6]) |=> flags_three[6]) else $error("software set lost");
   a_pending_needs_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (((flags_two & enable_two_reg) | (flags_three & enable_three_reg)) == 8'h00) |-> !peripheral_pending)
      else $error("pending without enabled flag");
endmodule // peripheral_irq_flag_bank
`default_nettype wire

// [hw/irq_flag_pkg.sv]
// Constants for the peripheral interrupt flag bank
package irq_flag_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] OFF_FLAGS_TWO = 4'h0;
   localparam logic [3:0] OFF_FLAGS_THREE = 4'h1;
   localparam logic [3:0] OFF_ENABLE_TWO = 4'h2;
   localparam logic [3:0] OFF_ENABLE_THREE = 4'h3;
   localparam logic [3:0] OFF_GLOBAL_CTRL = 4'h4;
   localparam logic [3:0] OFF_IRQ_STATUS = 4'h5;
   localparam logic [3:0] OFF_IRQ_MASK = 4'h6;
   // ----------------------------------------
   // Implemented bits and reset values
   // ----------------------------------------
   localparam logic [7:0] MASK_TWO = 8'hFD;
   localparam logic [7:0] MASK_THREE = 8'h7A;
   localparam logic [7:0] MASK_GLOBAL = 8'hC0;
   localparam logic [7:0] MASK_STATUS = 8'h03;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int GLOBAL_EN_BIT = 7;
   localparam int PERIPH_EN_BIT = 6;
   localparam int EVT_TWO_BIT = 0;
   localparam int EVT_THREE_BIT = 1;
endpackage

// [hw/flag_reg.sv]
// One 8-bit sticky flag register, set by hardware, written by software
`timescale 1ns/1ps
`default_nettype none
module flag_reg #(
   parameter logic [7:0] IMPL = 8'hFF
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Software write
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // Hardware set
   input wire logic [7:0] set_in,
   // State
   output logic [7:0] flags,
   output logic new_event
);
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] base;
   // Set wins over a write in the same cycle
   assign base = wr_en ? wr_data : flags_reg;
   assign flags_next = (base | set_in) & IMPL;
   assign flags = flags_reg;
   assign new_event = |(set_in & IMPL & ~flags_reg);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flags_reg <= irq_flag_pkg::RESET_VALUE;
      end else begin
         flags_reg <= flags_next;
      end
   end
endmodule // flag_reg
`default_nettype wire

// [verif/peripheral_irq_flag_bank_tb.sv]
// Self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_bank_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [11:0] evt = 12'h000;
   logic peripheral_pending;
   logic irq;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int seed = 32'h72D5;
   logic [7:0] e2, e3, g, m, x2, x3;
   logic [11:0] ev;
   always #2.5 ref_clk = ~ref_clk;
   peripheral_irq_flag_bank DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_fail_evt(evt[6]),
      .comparator_two_evt(evt[5]), .comparator_one_evt(evt[4]), .eeprom_write_done_evt(evt[3]),
      .serial_bus_collision_evt(evt[2]), .lcd_module_evt(evt[1]), .capcomp_two_evt(evt[0]),
      .capcomp_three_evt(evt[9]), .capcomp_four_evt(evt[10]), .capcomp_five_evt(evt[11]),
      .timer_six_match_evt(evt[8]), .timer_four_match_evt(evt[7]),
      .peripheral_pending(peripheral_pending), .irq(irq));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] exp_two(input logic [11:0] e);
      return {e[6:1], 1'b0, e[0]};
   endfunction
   function automatic logic [7:0] exp_three(input logic [11:0] e);
      return {1'b0, e[11:8], 1'b0, e[7], 1'b0};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Hang guard, well above the expected run
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         final_report;
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++) rd_chk(a[3:0], 8'h00);
      wr(irq_flag_pkg::OFF_FLAGS_TWO, 8'hFF);
      wr(irq_flag_pkg::OFF_FLAGS_THREE, 8'hFF);
      rd_chk(irq_flag_pkg::OFF_FLAGS_TWO, irq_flag_pkg::MASK_TWO);
      rd_chk(irq_flag_pkg::OFF_FLAGS_THREE, irq_flag_pkg::MASK_THREE);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(irq_flag_pkg::OFF_FLAGS_TWO, 8'h00);
      rd_chk(irq_flag_pkg::OFF_FLAGS_THREE, 8'h00);
      // First twelve passes walk each source alone, the rest are random
      for (int i = 0; i < 30; i++) begin
         ev = (i < 12) ? (12'h001 << i) : 12'($random(seed));
         e2 = 8'($random(seed));
         e3 = 8'($random(seed));
         g = 8'($random(seed));
         m = 8'($random(seed));
         x2 = exp_two(ev);
         x3 = exp_three(ev);
         wr(irq_flag_pkg::OFF_FLAGS_TWO, 8'h00);
         wr(irq_flag_pkg::OFF_FLAGS_THREE, 8'h00);
         wr(irq_flag_pkg::OFF_IRQ_STATUS, 8'h03);
         wr(irq_flag_pkg::OFF_ENABLE_TWO, e2);
         wr(irq_flag_pkg::OFF_ENABLE_THREE, e3);
         wr(irq_flag_pkg::OFF_GLOBAL_CTRL, g);
         wr(irq_flag_pkg::OFF_IRQ_MASK, m);
         rd_chk(irq_flag_pkg::OFF_ENABLE_TWO, e2 & irq_flag_pkg::MASK_TWO);
         rd_chk(irq_flag_pkg::OFF_ENABLE_THREE, e3 & irq_flag_pkg::MASK_THREE);
         rd_chk(irq_flag_pkg::OFF_GLOBAL_CTRL, g & irq_flag_pkg::MASK_GLOBAL);
         rd_chk(irq_flag_pkg::OFF_IRQ_MASK, m & irq_flag_pkg::MASK_STATUS);
         chk({7'h00, irq}, 8'h00);
         @(posedge ref_clk);
         evt <= ev;
         @(posedge ref_clk);
         evt <= 12'h000;
         rd_chk(irq_flag_pkg::OFF_FLAGS_TWO, x2);
         rd_chk(irq_flag_pkg::OFF_FLAGS_THREE, x3);
         chk({7'h00, peripheral_pending}, {7'h00, g[6] & ((|(x2 & e2)) | (|(x3 & e3)))});
         chk({7'h00, irq}, {7'h00, |(m[1:0] & {|x3, |x2})});
         rd_chk(irq_flag_pkg::OFF_IRQ_STATUS, {6'h00, |x3, |x2});
      end
      // Event and software clear in the same cycle: the event wins
      @(posedge ref_clk);
      evt <= 12'h040;
      reg_wr <= 1'b1;
      reg_addr <= irq_flag_pkg::OFF_FLAGS_TWO;
      reg_wdata <= 8'h00;
      @(posedge ref_clk);
      evt <= 12'h000;
      reg_wr <= 1'b0;
      rd_chk(irq_flag_pkg::OFF_FLAGS_TWO, 8'h80);
      final_report;
   end
endmodule // peripheral_irq_flag_bank_tb
`default_nettype wire
